// *** core/sdio_interrupt_enable_upper.sv ***
// AXI4-Lite interrupt enable, sticky status and interrupt for the upper SDIO sources
`timescale 1ns/1ps
`include "sdio_irq_params.svh"

module sdio_interrupt_enable_upper (
  input wire logic ref_clk, // Bus clock, 100 MHz
  input wire logic resetn, // Async reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic [2:0] s_axi_awprot, // Write protection, ignored
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic [2:0] s_axi_arprot, // Read protection, ignored
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire sdio_irq_pkg::sdio_flags_t src_flags, // Source flag levels
  output logic irq // Interrupt, active high level
);

  // Byte lane mask from the write strobes
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // Word address match; low two address bits are ignored
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    addr_hit = (addr[7:2] == ofs[7:2]);
  endfunction

  // Ten flags placed at bits 22 down to 13, the rest zero
  function automatic logic [31:0] place_field(input sdio_irq_pkg::sdio_flags_t f);
    place_field = {9'h000, f, 13'h0000};
  endfunction

  // Response code; unmapped words are refused with a slave error
  function automatic logic [1:0] resp_code(input logic mapped);
    resp_code = mapped ? `RESP_OKAY : `RESP_SLVERR;
  endfunction

  // Write channel state
  sdio_irq_pkg::wr_state_t wr_state_ff;
  sdio_irq_pkg::wr_state_t nxt_wr_state;
  logic aw_got_ff;
  logic w_got_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;

  // Read channel state
  sdio_irq_pkg::rd_state_t rd_state_ff;
  sdio_irq_pkg::rd_state_t nxt_rd_state;
  logic arready_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;

  // Register contents
  logic [31:0] ien_ff;
  logic [31:0] sticky_ff;
  logic irq_ff;

  // Outputs come straight from flip-flops
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign irq = irq_ff;

  // Channel handshakes
  wire aw_hs = s_axi_awvalid && awready_ff;
  wire w_hs = s_axi_wvalid && wready_ff;
  wire b_hs = bvalid_ff && s_axi_bready;
  wire ar_hs = s_axi_arvalid && arready_ff;
  wire r_hs = rvalid_ff && s_axi_rready;

  // Write fires once address and data are both held, in either order
  wire wr_collect = (wr_state_ff == sdio_irq_pkg::WR_COLLECT);
  wire do_write = wr_collect && aw_got_ff && w_got_ff;

  // Capture of address and data, released after the write
  wire nxt_aw_got = do_write ? 1'b0 : (aw_got_ff || aw_hs);
  wire nxt_w_got = do_write ? 1'b0 : (w_got_ff || w_hs);
  wire [7:0] nxt_awaddr = aw_hs ? s_axi_awaddr : awaddr_ff;
  wire [31:0] nxt_wdata = w_hs ? s_axi_wdata : wdata_ff;
  wire [3:0] nxt_wstrb = w_hs ? s_axi_wstrb : wstrb_ff;

  // Write address decode
  wire wr_hit_en = addr_hit(awaddr_ff, `OFS_INT_ENABLE);
  wire wr_hit_st = addr_hit(awaddr_ff, `OFS_INT_STATUS);
  wire wr_hit_raw = addr_hit(awaddr_ff, `OFS_INT_RAW);
  wire wr_mapped = wr_hit_en || wr_hit_st || wr_hit_raw;
  wire [31:0] wr_lanes = lane_mask(wstrb_ff);

  // Write sequencer
  always_comb
  begin
    nxt_wr_state = wr_state_ff;
    case (wr_state_ff)
      sdio_irq_pkg::WR_COLLECT:
      begin
        if (do_write)
        begin
          nxt_wr_state = sdio_irq_pkg::WR_RESP;
        end
      end
      sdio_irq_pkg::WR_RESP:
      begin
        if (b_hs)
        begin
          nxt_wr_state = sdio_irq_pkg::WR_COLLECT;
        end
      end
      default:
      begin
        nxt_wr_state = sdio_irq_pkg::WR_COLLECT;
      end
    endcase
  end

  // Ready only while that channel's item is still missing
  wire nxt_wr_open = (nxt_wr_state == sdio_irq_pkg::WR_COLLECT);
  wire nxt_awready = nxt_wr_open && !nxt_aw_got;
  wire nxt_wready = nxt_wr_open && !nxt_w_got;

  // Response held until the master takes it
  wire nxt_bvalid = do_write ? 1'b1 : (bvalid_ff && !s_axi_bready);
  wire [1:0] nxt_bresp = do_write ? resp_code(wr_mapped) : bresp_ff;

  // Write channel registers
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_state_ff <= sdio_irq_pkg::WR_COLLECT;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
    end
    else
    begin
      wr_state_ff <= nxt_wr_state;
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
    end
  end

  // Write payload holding registers
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end
    else
    begin
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
    end
  end

  // Enable register: plain store of ones and zeros, reserved bits dropped
  wire en_write = do_write && wr_hit_en;
  wire [31:0] en_merge = (ien_ff & ~wr_lanes) | (wdata_ff & wr_lanes);
  wire [31:0] nxt_ien = (en_write ? en_merge : ien_ff) & `FIELD_MASK;

  // Source flags placed at bits 22 down to 13
  wire [31:0] flag_word = place_field(src_flags);

  // Sticky status, cleared by writing one; a new event wins over the clear
  wire st_write = do_write && wr_hit_st;
  wire [31:0] st_clear = st_write ? (wdata_ff & wr_lanes) : 32'h00000000;
  wire [31:0] nxt_sticky = ((sticky_ff & ~st_clear) | flag_word) & `FIELD_MASK;

  // One term per source, status ANDed with its enable; next values are used
  // so irq moves on the same edge as the registers, not one cycle behind
  wire nxt_irq =
    (nxt_sticky[`BIT_CARD_IRQ] && nxt_ien[`BIT_CARD_IRQ]) ||
    (nxt_sticky[`BIT_RX_AVAIL] && nxt_ien[`BIT_RX_AVAIL]) ||
    (nxt_sticky[`BIT_TX_AVAIL] && nxt_ien[`BIT_TX_AVAIL]) ||
    (nxt_sticky[`BIT_RX_EMPTY] && nxt_ien[`BIT_RX_EMPTY]) ||
    (nxt_sticky[`BIT_TX_EMPTY] && nxt_ien[`BIT_TX_EMPTY]) ||
    (nxt_sticky[`BIT_RX_FULL] && nxt_ien[`BIT_RX_FULL]) ||
    (nxt_sticky[`BIT_TX_FULL] && nxt_ien[`BIT_TX_FULL]) ||
    (nxt_sticky[`BIT_RX_HALF] && nxt_ien[`BIT_RX_HALF]) ||
    (nxt_sticky[`BIT_TX_HALF] && nxt_ien[`BIT_TX_HALF]) ||
    (nxt_sticky[`BIT_RX_ACT] && nxt_ien[`BIT_RX_ACT]);

  // Enable register
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ien_ff <= `RST_INT_ENABLE;
    end
    else
    begin
      ien_ff <= nxt_ien;
    end
  end

  // Sticky status register
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sticky_ff <= `RST_INT_STATUS;
    end
    else
    begin
      sticky_ff <= nxt_sticky;
    end
  end

  // Interrupt flop; kept apart so the output stays a bare register
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= nxt_irq;
    end
  end

  // Enable fields by name, as stored
  wire card_irq_received_en = ien_ff[`BIT_CARD_IRQ];
  wire rx_data_available_en = ien_ff[`BIT_RX_AVAIL];
  wire tx_data_available_en = ien_ff[`BIT_TX_AVAIL];
  wire rx_fifo_empty_en = ien_ff[`BIT_RX_EMPTY];
  wire tx_fifo_empty_en = ien_ff[`BIT_TX_EMPTY];
  wire rx_fifo_full_en = ien_ff[`BIT_RX_FULL];
  wire tx_fifo_full_en = ien_ff[`BIT_TX_FULL];
  wire rx_fifo_half_full_en = ien_ff[`BIT_RX_HALF];
  wire tx_fifo_half_empty_en = ien_ff[`BIT_TX_HALF];
  wire receive_in_progress_en = ien_ff[`BIT_RX_ACT];

  // Enable read-back built from the fields, so reserved bits cannot leak out
  wire sdio_irq_pkg::sdio_flags_t en_fields = {
    card_irq_received_en,
    rx_data_available_en,
    tx_data_available_en,
    rx_fifo_empty_en,
    tx_fifo_empty_en,
    rx_fifo_full_en,
    tx_fifo_full_en,
    rx_fifo_half_full_en,
    tx_fifo_half_empty_en,
    receive_in_progress_en
  };

  // Read address decode
  wire rd_hit_en = addr_hit(s_axi_araddr, `OFS_INT_ENABLE);
  wire rd_hit_st = addr_hit(s_axi_araddr, `OFS_INT_STATUS);
  wire rd_hit_raw = addr_hit(s_axi_araddr, `OFS_INT_RAW);
  wire rd_mapped = rd_hit_en || rd_hit_st || rd_hit_raw;

  // Read data select; unmapped words read zero
  wire [31:0] rd_en_word = rd_hit_en ? place_field(en_fields) : 32'h00000000;
  wire [31:0] rd_st_word = rd_hit_st ? sticky_ff : 32'h00000000;
  wire [31:0] rd_raw_word = rd_hit_raw ? flag_word : 32'h00000000;
  wire [31:0] rd_word = (rd_en_word | rd_st_word | rd_raw_word) & `FIELD_MASK;

  // Read sequencer
  always_comb
  begin
    nxt_rd_state = rd_state_ff;
    case (rd_state_ff)
      sdio_irq_pkg::RD_IDLE:
      begin
        if (ar_hs)
        begin
          nxt_rd_state = sdio_irq_pkg::RD_DATA;
        end
      end
      sdio_irq_pkg::RD_DATA:
      begin
        if (r_hs)
        begin
          nxt_rd_state = sdio_irq_pkg::RD_IDLE;
        end
      end
      default:
      begin
        nxt_rd_state = sdio_irq_pkg::RD_IDLE;
      end
    endcase
  end

  // One read at a time: address refused while data is pending
  wire nxt_arready = (nxt_rd_state == sdio_irq_pkg::RD_IDLE);
  wire nxt_rvalid = (nxt_rd_state == sdio_irq_pkg::RD_DATA);
  wire [31:0] nxt_rdata = ar_hs ? rd_word : rdata_ff;
  wire [1:0] nxt_rresp = ar_hs ? resp_code(rd_mapped) : rresp_ff;

  // Read channel registers
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_state_ff <= sdio_irq_pkg::RD_IDLE;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= `RESP_OKAY;
      rdata_ff <= 32'h00000000;
    end
    else
    begin
      rd_state_ff <= nxt_rd_state;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
    end
  end

endmodule

// *** shared/sdio_irq_params.svh ***
// Offsets, field positions, reset values and response codes of the interrupt enable block
//
// Operation
// - An interrupt source reaches the interrupt only while its enable bit is one.
// - Bits 31 to 23 are reserved, reset to zero, always read zero.
// - Bit 22 enables the SD I/O card interrupt source, reset 0.
// - Bit 21 enables the receive data available source, reset 0.
// - Bit 20 enables the transmit data available source, reset 0.
// - Bit 19 enables the receive FIFO empty source, reset 0.
// - Bit 18 enables the transmit FIFO empty source, reset 0.
// - Bit 17 enables the receive FIFO full source, reset 0.
// - Bit 16 enables the transmit FIFO full source, reset 0.
// - Bit 15 enables the receive FIFO half full source, reset 0.
// - Bit 14 enables the transmit FIFO half empty source, reset 0.
// - Bit 13 enables the receive in progress source, reset 0.
`ifndef SDIO_IRQ_PARAMS_SVH
`define SDIO_IRQ_PARAMS_SVH

// Register byte offsets
`define OFS_INT_ENABLE 8'h00
`define OFS_INT_STATUS 8'h04
`define OFS_INT_RAW 8'h08

// Field positions
`define BIT_CARD_IRQ 22
`define BIT_RX_AVAIL 21
`define BIT_TX_AVAIL 20
`define BIT_RX_EMPTY 19
`define BIT_TX_EMPTY 18
`define BIT_RX_FULL 17
`define BIT_TX_FULL 16
`define BIT_RX_HALF 15
`define BIT_TX_HALF 14
`define BIT_RX_ACT 13
`define FIELD_LSB 13

// Implemented bits and reset values
`define FIELD_MASK 32'h007FE000
`define RST_INT_ENABLE 32'h00000000
`define RST_INT_STATUS 32'h00000000

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** shared/sdio_irq_pkg.sv ***
// Types shared by the interrupt enable block
package sdio_irq_pkg;

  // Source flags, most significant first, bit 22 down to bit 13
  typedef struct packed {
    logic card_irq_received;
    logic rx_data_available;
    logic tx_data_available;
    logic rx_fifo_empty;
    logic tx_fifo_empty;
    logic rx_fifo_full;
    logic tx_fifo_full;
    logic rx_fifo_half_full;
    logic tx_fifo_half_empty;
    logic receive_in_progress;
  } sdio_flags_t;

  // Write channel sequencer
  typedef enum logic [1:0] {
    WR_COLLECT = 2'h1,
    WR_RESP = 2'h2
  } wr_state_t;

  // Read channel sequencer
  typedef enum logic [1:0] {
    RD_IDLE = 2'h1,
    RD_DATA = 2'h2
  } rd_state_t;

endpackage

// *** tb/sdio_interrupt_enable_upper_sva.sv ***
// Checker for the bus handshakes and interrupt of the enable block
`timescale 1ns/1ps
module sdio_irq_checker (
  input wire logic ref_clk, // Bus clock
  input wire logic resetn, // Async reset, active low
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data ready
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire sdio_irq_pkg::sdio_flags_t src_flags, // Source flags
  input wire logic irq // Interrupt
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Address and data taken together, response two edges later
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence resp_late;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  AST_B_TIMING: assert property (both_taken |=> resp_late)
    else $error("write response not two edges after handshake");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  AST_B_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write slot open while response pending");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write response not retired");
  AST_R_TIMING: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not one edge after address");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped before taken");
  AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> s_axi_arready && !s_axi_rvalid)
    else $error("read not retired");
  // Sticky status: only a register write can lower the interrupt
  AST_IRQ_FALL: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
    else $error("interrupt fell without a write");
  AST_IRQ_RISE: assert property ($rose(irq) |-> $past(|src_flags) || $rose(s_axi_bvalid))
    else $error("interrupt rose without a cause");
  AST_IRQ_RESET: assert property ($rose(resetn) |-> !irq)
    else $error("interrupt high after reset");
endmodule
bind sdio_interrupt_enable_upper sdio_irq_checker sdio_irq_checker_inst (
  .ref_clk(ref_clk), .resetn(resetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .src_flags(src_flags), .irq(irq)
);

// *** tb/testbench.sv ***
// Self-checking bench for the upper interrupt enable block
`timescale 1ns/1ps
`include "sdio_irq_params.svh"
module testbench;
  logic ref_clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv, m;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  sdio_irq_pkg::sdio_flags_t src_flags;
  int errors, check_count;

  sdio_interrupt_enable_upper sdio_interrupt_enable_upper_inst (
    .ref_clk(ref_clk), .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .src_flags(src_flags), .irq(irq)
  );

  // Free-running bus clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // One write; response ready stays high so it is never missed
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    do @(posedge ref_clk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
  endtask

  task rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
  endtask

  task reset_values;
    rd(`OFS_INT_ENABLE);
    chk(rv, `RST_INT_ENABLE);
    rd(`OFS_INT_STATUS);
    chk(rv, `RST_INT_STATUS);
  endtask

  // Reserved bits, strobes and unmapped places
  task field_access;
    wr(`OFS_INT_ENABLE, 32'hFFFFFFFF, 4'hF);
    rd(`OFS_INT_ENABLE);
    chk(rv, `FIELD_MASK);
    wr(`OFS_INT_ENABLE, 32'h00000000, 4'h0);
    rd(`OFS_INT_ENABLE);
    chk(rv, `FIELD_MASK);
    wr(`OFS_INT_ENABLE, 32'h00000000, 4'hF);
    rd(`OFS_INT_ENABLE);
    chk(rv, 32'h00000000);
    wr(8'h0C, 32'hFFFFFFFF, 4'hF);
    chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
    rd(8'h0C);
    chk({rv[31:2], rs}, {30'h0, `RESP_SLVERR});
  endtask

  // Flags held through a clear: the set wins; the raw view follows the pins
  task set_wins;
    src_flags <= 10'h3FF;
    wr(`OFS_INT_STATUS, `FIELD_MASK, 4'hF);
    chk({30'h0, rs}, {30'h0, `RESP_OKAY});
    rd(`OFS_INT_RAW);
    chk(rv, `FIELD_MASK);
    rd(`OFS_INT_STATUS);
    chk(rv, `FIELD_MASK);
    chk({30'h0, rs}, {30'h0, `RESP_OKAY});
    chk({31'h0, irq}, 32'h1);
    src_flags <= '0;
    wr(`OFS_INT_STATUS, `FIELD_MASK, 4'hF);
    chk({31'h0, irq}, 32'h0);
    rd(`OFS_INT_STATUS);
    chk(rv, 32'h00000000);
  endtask

  // Each source: masked, then enabled, then cleared
  task per_source;
    for (int i = 0; i < 10; i++)
    begin
      m = 32'h00000001 << (i + `FIELD_LSB);
      wr(`OFS_INT_ENABLE, `FIELD_MASK ^ m, 4'hF);
      src_flags <= m[22:13];
      @(posedge ref_clk);
      src_flags <= '0;
      repeat (2) @(posedge ref_clk);
      chk({31'h0, irq}, 32'h0);
      rd(`OFS_INT_STATUS);
      chk(rv, m);
      wr(`OFS_INT_ENABLE, m, 4'hF);
      chk({31'h0, irq}, 32'h1);
      wr(`OFS_INT_STATUS, m, 4'hF);
      chk({31'h0, irq}, 32'h0);
    end
  endtask

  task end_of_test;
    $display("errors %0d, checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    errors++;
    end_of_test;
  end

  // Reset, then the scenarios in turn
  initial
  begin
    errors = 0;
    check_count = 0;
    resetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    {s_axi_awprot, s_axi_arprot} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    src_flags = '0;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    reset_values;
    field_access;
    per_source;
    set_wins;
    end_of_test;
  end
endmodule
